// ### verilog/ptc_map.svh
// register offsets, field positions, reset values and timing counts for the paired timer
`ifndef PTC_MAP_SVH
`define PTC_MAP_SVH
`define PTC_ADDR_LOW_CTRL    4'h0
`define PTC_ADDR_HIGH_CTRL   4'h1
`define PTC_ADDR_LOW_COUNT   4'h2
`define PTC_ADDR_HIGH_COUNT  4'h3
`define PTC_ADDR_LOW_PERIOD  4'h4
`define PTC_ADDR_HIGH_PERIOD 4'h5
`define PTC_ADDR_IRQ_STATUS  4'h6
`define PTC_ADDR_IRQ_MASK    4'h7
`define PTC_BIT_RUN          15
`define PTC_BIT_IDLE_HALT    13
`define PTC_BIT_GATE         6
`define PTC_BIT_PS_HI        5
`define PTC_BIT_PS_LO        4
`define PTC_BIT_JOIN         3
`define PTC_BIT_SRC          1
`define PTC_LOW_CTRL_MASK    16'hA07A
`define PTC_HIGH_CTRL_MASK   16'hA072
`define PTC_CTRL_RESET       16'h0000
`define PTC_PERIOD_RESET     16'hFFFF
`define PTC_IRQ_WIDTH        2
`define PTC_INT_CLK_DIV      2
`endif

// ### verilog/ptc_pkg.sv
// types shared by the paired timer modules
package ptc_pkg;
  typedef logic [15:0] ptc_word_t;
  typedef enum logic [1:0] {
    PTC_PS_1   = 2'h0,
    PTC_PS_8   = 2'h1,
    PTC_PS_64  = 2'h2,
    PTC_PS_256 = 2'h3
  } ptc_prescale_t;
endpackage

// ### verilog/ptc_tick_if.sv
// per-timer clock selection and tick bundle between top and prescaler
`timescale 1ns/100ps
interface ptc_tick_if;
  logic                   srcSel;
  logic                   gateEn;
  logic                   run;
  logic                   hold;
  ptc_pkg::ptc_prescale_t prescale;
  logic                   tick;
  modport ctrl (output srcSel, output gateEn, output run, output hold, output prescale, input tick);
  modport gen  (input srcSel, input gateEn, input run, input hold, input prescale, output tick);
endinterface

// ### verilog/ptc_prescaler.sv
// clock source selection, gating and prescale divider for one timer
`timescale 1ns/100ps
`include "ptc_map.svh"
module ptc_prescaler
(
  // clock and reset
  input  wire logic clock,
  input  wire logic rstn,
  // sources
  input  wire logic intTick,
  input  wire logic extClock,
  input  wire logic gatePin,
  // control and tick
  ptc_tick_if.gen   tk
);
  logic       extPrev;
  logic [7:0] div;
  logic       next_extPrev;
  logic [7:0] next_div;
  logic       srcTick;
  logic       atLimit;
  logic [7:0] limit;

  always_comb
  begin
    // external source: rising edges; gating ignored then
    if (tk.srcSel)
      srcTick = extClock && !extPrev;
    else if (tk.gateEn)
      srcTick = intTick && gatePin;
    else
      srcTick = intTick;
    unique case (tk.prescale)
      ptc_pkg::PTC_PS_1:   limit = 8'h00;
      ptc_pkg::PTC_PS_8:   limit = 8'h07;
      ptc_pkg::PTC_PS_64:  limit = 8'h3F;
      ptc_pkg::PTC_PS_256: limit = 8'hFF;
    endcase
    atLimit       = (div == limit);
    next_extPrev  = extClock;
    next_div      = div;
    tk.tick       = 1'b0;
    if (!tk.run)
      next_div = 8'h00;
    else if (srcTick && !tk.hold)
    begin
      next_div = atLimit ? 8'h00 : div + 8'h01;
      tk.tick  = atLimit;
    end
  end

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      extPrev  <= 1'b0;
      div      <= 8'h00;
    end
    else
    begin
      extPrev  <= next_extPrev;
      div      <= next_div;
    end
  end
endmodule

// ### verilog/ptc_paired_timer.sv
// paired 16/32-bit timer with control registers, period match and interrupt
`timescale 1ns/100ps
`include "ptc_map.svh"
module ptc_paired_timer
(
  // clock and reset
  input  wire logic        clock,
  input  wire logic        rstn,
  // register port
  input  wire logic [3:0]  regAddr,
  input  wire logic [15:0] regWdata,
  input  wire logic        regWrite,
  input  wire logic        regRead,
  output logic      [15:0] regRdata,
  // pins and device state
  input  wire logic        lowExtClockPin,
  input  wire logic        highExtClockPin,
  input  wire logic        lowGatePin,
  input  wire logic        highGatePin,
  input  wire logic        idleMode,
  // events
  output logic             irq,
  output logic             adcTrigger
);
  ptc_pkg::ptc_word_t lowCtrl;
  ptc_pkg::ptc_word_t highCtrl;
  ptc_pkg::ptc_word_t lowCount;
  ptc_pkg::ptc_word_t highCount;
  ptc_pkg::ptc_word_t lowPeriod;
  ptc_pkg::ptc_word_t highPeriod;
  logic [`PTC_IRQ_WIDTH-1:0] irqStatus;
  logic [`PTC_IRQ_WIDTH-1:0] irqMask;
  logic                      intTick;
  ptc_pkg::ptc_word_t next_lowCtrl;
  ptc_pkg::ptc_word_t next_highCtrl;
  ptc_pkg::ptc_word_t next_lowCount;
  ptc_pkg::ptc_word_t next_highCount;
  ptc_pkg::ptc_word_t next_lowPeriod;
  ptc_pkg::ptc_word_t next_highPeriod;
  logic [`PTC_IRQ_WIDTH-1:0] next_irqStatus;
  logic [`PTC_IRQ_WIDTH-1:0] next_irqMask;
  logic                      next_intTick;
  ptc_pkg::ptc_word_t next_regRdata;
  logic                      next_irq;
  logic                      next_adcTrigger;
  logic                      joined;
  logic                      lowMatch;
  logic                      highMatch;
  logic                      joinMatch;
  logic [`PTC_IRQ_WIDTH-1:0] events;

  ptc_tick_if lowTk ();
  ptc_tick_if highTk ();

  // control steering: paired mode takes everything from the low register
  assign joined          = lowCtrl[`PTC_BIT_JOIN];
  assign lowTk.srcSel    = lowCtrl[`PTC_BIT_SRC];
  assign lowTk.gateEn    = lowCtrl[`PTC_BIT_GATE];
  assign lowTk.run       = lowCtrl[`PTC_BIT_RUN];
  assign lowTk.hold      = idleMode && lowCtrl[`PTC_BIT_IDLE_HALT];
  assign lowTk.prescale  = ptc_pkg::ptc_prescale_t'(lowCtrl[`PTC_BIT_PS_HI:`PTC_BIT_PS_LO]);
  assign highTk.srcSel   = highCtrl[`PTC_BIT_SRC];
  assign highTk.gateEn   = highCtrl[`PTC_BIT_GATE];
  assign highTk.run      = !joined && highCtrl[`PTC_BIT_RUN];
  assign highTk.hold     = idleMode && highCtrl[`PTC_BIT_IDLE_HALT];
  assign highTk.prescale = ptc_pkg::ptc_prescale_t'(highCtrl[`PTC_BIT_PS_HI:`PTC_BIT_PS_LO]);

  ptc_prescaler lowPs
  (
    .clock    (clock),
    .rstn     (rstn),
    .intTick  (intTick),
    .extClock (lowExtClockPin),
    .gatePin  (lowGatePin),
    .tk       (lowTk.gen)
  );

  ptc_prescaler highPs
  (
    .clock    (clock),
    .rstn     (rstn),
    .intTick  (intTick),
    .extClock (highExtClockPin),
    .gatePin  (highGatePin),
    .tk       (highTk.gen)
  );

  assign lowMatch  = (lowCount == lowPeriod);
  assign highMatch = (highCount == highPeriod);
  assign joinMatch = lowMatch && highMatch;

  always_comb
  begin
    // internal clock is the system clock divided by two
    next_intTick    = !intTick;
    next_lowCtrl    = lowCtrl;
    next_highCtrl   = highCtrl;
    next_lowCount   = lowCount;
    next_highCount  = highCount;
    next_lowPeriod  = lowPeriod;
    next_highPeriod = highPeriod;
    next_irqMask    = irqMask;
    events          = '0;
    if (joined)
    begin
      if (lowTk.tick)
      begin
        if (joinMatch)
        begin
          next_lowCount  = 16'h0000;
          next_highCount = 16'h0000;
          events[1]      = 1'b1;
        end
        else
        begin
          next_lowCount = lowCount + 16'h0001;
          if (lowCount == 16'hFFFF)
            next_highCount = highCount + 16'h0001;
        end
      end
    end
    else
    begin
      if (lowTk.tick)
      begin
        next_lowCount = lowMatch ? 16'h0000 : lowCount + 16'h0001;
        events[0]     = lowMatch;
      end
      if (highTk.tick)
      begin
        next_highCount = highMatch ? 16'h0000 : highCount + 16'h0001;
        events[1]      = highMatch;
      end
    end
    if (regWrite)
    begin
      unique case (regAddr)
        `PTC_ADDR_LOW_CTRL:    next_lowCtrl = regWdata & `PTC_LOW_CTRL_MASK;
        `PTC_ADDR_HIGH_CTRL:   next_highCtrl = regWdata & `PTC_HIGH_CTRL_MASK;
        `PTC_ADDR_LOW_COUNT:   next_lowCount = regWdata;
        `PTC_ADDR_HIGH_COUNT:  next_highCount = regWdata;
        `PTC_ADDR_LOW_PERIOD:  next_lowPeriod = regWdata;
        `PTC_ADDR_HIGH_PERIOD: next_highPeriod = regWdata;
        `PTC_ADDR_IRQ_MASK:    next_irqMask = regWdata[`PTC_IRQ_WIDTH-1:0];
        default:               next_irqMask = irqMask;
      endcase
    end
    // write-one-to-clear, a new event wins
    next_irqStatus = irqStatus;
    if (regWrite && regAddr == `PTC_ADDR_IRQ_STATUS)
      next_irqStatus = irqStatus & ~regWdata[`PTC_IRQ_WIDTH-1:0];
    next_irqStatus  = next_irqStatus | events;
    next_irq        = |(next_irqStatus & next_irqMask);
    next_adcTrigger = events[1];
    next_regRdata   = 16'h0000;
    if (regRead)
    begin
      unique case (regAddr)
        `PTC_ADDR_LOW_CTRL:    next_regRdata = lowCtrl;
        `PTC_ADDR_HIGH_CTRL:   next_regRdata = highCtrl;
        `PTC_ADDR_LOW_COUNT:   next_regRdata = lowCount;
        `PTC_ADDR_HIGH_COUNT:  next_regRdata = highCount;
        `PTC_ADDR_LOW_PERIOD:  next_regRdata = lowPeriod;
        `PTC_ADDR_HIGH_PERIOD: next_regRdata = highPeriod;
        `PTC_ADDR_IRQ_STATUS:  next_regRdata = {14'h0000, irqStatus};
        `PTC_ADDR_IRQ_MASK:    next_regRdata = {14'h0000, irqMask};
        default:               next_regRdata = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      lowCtrl    <= `PTC_CTRL_RESET;
      highCtrl   <= `PTC_CTRL_RESET;
      lowCount   <= 16'h0000;
      highCount  <= 16'h0000;
      lowPeriod  <= `PTC_PERIOD_RESET;
      highPeriod <= `PTC_PERIOD_RESET;
      irqStatus  <= '0;
      irqMask    <= '0;
      intTick    <= 1'b0;
      regRdata   <= 16'h0000;
      irq        <= 1'b0;
      adcTrigger <= 1'b0;
    end
    else
    begin
      lowCtrl    <= next_lowCtrl;
      highCtrl   <= next_highCtrl;
      lowCount   <= next_lowCount;
      highCount  <= next_highCount;
      lowPeriod  <= next_lowPeriod;
      highPeriod <= next_highPeriod;
      irqStatus  <= next_irqStatus;
      irqMask    <= next_irqMask;
      intTick    <= next_intTick;
      regRdata   <= next_regRdata;
      irq        <= next_irq;
      adcTrigger <= next_adcTrigger;
    end
  end
endmodule

// ### tb/ptc_paired_timer_sva.sv
// port assertions for the paired timer
`timescale 1ns/100ps
module ptc_chk
(
  // clock and reset
  input wire logic        clock,
  input wire logic        rstn,
  // register port
  input wire logic [3:0]  regAddr,
  input wire logic [15:0] regWdata,
  input wire logic        regWrite,
  input wire logic        regRead,
  input wire logic [15:0] regRdata,
  // events
  input wire logic        irq,
  input wire logic        adcTrigger
);
  logic [1:0] mask;
  logic [1:0] next_mask;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);
  // shadow of the interrupt mask
  always_comb next_mask = (regWrite && regAddr == 4'h7) ? regWdata[1:0] : mask;
  always_ff @(posedge clock or negedge rstn)
    if (!rstn)
      mask <= 2'h0;
    else
      mask <= next_mask;
  property p_idle; !regRead |=> regRdata == 16'h0000; endproperty
  a_idle: assert property (p_idle) else $error("stray read data");
  property p_lo; regRead && regAddr == 4'h0 |=> (regRdata & 16'h5F85) == 16'h0000; endproperty
  a_lo: assert property (p_lo) else $error("low control unused bit set");
  property p_hi; regRead && regAddr == 4'h1 |=> (regRdata & 16'h5F8D) == 16'h0000; endproperty
  a_hi: assert property (p_hi) else $error("high control unused bit set");
  property p_wrrd;
    regWrite && regAddr == 4'h1 ##1 regRead && regAddr == 4'h1 |=> regRdata == ($past(regWdata, 2) & 16'hA072);
  endproperty
  a_wrrd: assert property (p_wrrd) else $error("high control readback wrong");
  property p_adc; adcTrigger |=> !adcTrigger; endproperty
  a_adc: assert property (p_adc) else $error("trigger longer than one cycle");
  property p_mask; (mask == 2'h0) [*2] |-> !irq; endproperty
  a_mask: assert property (p_mask) else $error("irq while all masked");
  property p_rst; $rose(rstn) |-> !irq && !adcTrigger; endproperty
  a_rst: assert property (p_rst) else $error("events active after reset");
  property p_irq; adcTrigger && mask[1] |-> ##[0:1] irq; endproperty
  a_irq: assert property (p_irq) else $error("match without irq");
  c_adc: cover property (adcTrigger);
  c_irq: cover property (irq);
  c_wrrd: cover property (regWrite ##1 regRead);
endmodule
bind ptc_paired_timer ptc_chk i_chk (.clock(clock), .rstn(rstn), .regAddr(regAddr), .regWdata(regWdata),
  .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata), .irq(irq), .adcTrigger(adcTrigger));

// ### tb/ptc_pin_model.sv
// external clock and gate pin source
`timescale 1ns/100ps
module ptc_pin_model
(
  // clock and reset
  input  wire logic       clock,
  input  wire logic       rstn,
  // command
  input  wire logic       start,
  input  wire logic [8:0] pulses,
  input  wire logic [1:0] pinSel,
  input  wire logic [1:0] gap,
  input  wire logic [1:0] gateLevel,
  output logic            busy,
  // pins
  output logic            lowExtClockPin,
  output logic            highExtClockPin,
  output logic            lowGatePin,
  output logic            highGatePin
);
  logic [8:0] remain;
  logic [2:0] phase;
  logic [1:0] sel;
  logic [1:0] width;
  always @(posedge clock or negedge rstn)
    if (!rstn)
    begin
      remain <= 9'h000;
      phase <= 3'h0;
      sel <= 2'h0;
      width <= 2'h1;
      {highGatePin, lowGatePin} <= 2'h0;
    end
    else
    begin
      {highGatePin, lowGatePin} <= gateLevel;
      if (start)
      begin
        remain <= pulses;
        phase <= 3'h0;
        sel <= pinSel;
        width <= gap;
      end
      else if (remain != 9'h000)
      begin
        phase <= (phase == {width, 1'b0} - 3'h1) ? 3'h0 : phase + 3'h1;
        if (phase == {width, 1'b0} - 3'h1)
          remain <= remain - 9'h001;
      end
    end
  // external clock pins rest low outside a burst; gate pins follow gateLevel
  assign busy = remain != 9'h000;
  assign lowExtClockPin = busy && sel[0] && phase < {1'b0, width};
  assign highExtClockPin = busy && sel[1] && phase < {1'b0, width};
endmodule

// ### tb/tb_ptc_paired_timer.sv
// self-checking bench for the paired timer
`timescale 1ns/100ps
module tb_ptc_paired_timer;
  logic        clock, rstn, regWrite, regRead, idleMode, irq, adcTrigger, start, busy, rdPend, irqSeen;
  logic        lowExtClockPin, highExtClockPin, lowGatePin, highGatePin;
  logic [3:0]  regAddr;
  logic [15:0] regWdata, regRdata, trigCount;
  logic [8:0]  pulses;
  logic [1:0]  pinSel, gap, gateLevel;
  logic [15:0] expQ[$];
  logic [15:0] psExp [4] = '{16'h0100, 16'h0020, 16'h0004, 16'h0001};
  logic [31:0] r;
  integer      seed, i, failCount, totalChecks;
  ptc_paired_timer i_dut (.clock, .rstn, .regAddr, .regWdata, .regWrite, .regRead, .regRdata, .lowExtClockPin,
    .highExtClockPin, .lowGatePin, .highGatePin, .idleMode, .irq, .adcTrigger);
  ptc_pin_model i_pins (.clock, .rstn, .start, .pulses, .pinSel, .gap, .gateLevel, .busy, .lowExtClockPin,
    .highExtClockPin, .lowGatePin, .highGatePin);
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    totalChecks++;
    if (seen !== exp)
    begin
      failCount++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic end_sim;
    $display("checks=%0d mismatches=%0d", totalChecks, failCount);
    if (failCount == 0 && totalChecks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic idle;
    regWrite <= 1'b0;
    regRead <= 1'b0;
    @(posedge clock);
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    regAddr <= a;
    regWdata <= d;
    regWrite <= 1'b1;
    regRead <= 1'b0;
    @(posedge clock);
  endtask
  task automatic rd(input logic [3:0] a, input logic [15:0] e);
    expQ.push_back(e);
    regAddr <= a;
    regRead <= 1'b1;
    regWrite <= 1'b0;
    @(posedge clock);
  endtask
  task automatic pulse(input logic [8:0] n, input logic [1:0] s, input logic [1:0] g);
    integer k;
    idle;
    pulses <= n;
    pinSel <= s;
    gap <= g;
    start <= 1'b1;
    @(posedge clock);
    start <= 1'b0;
    @(posedge clock);
    for (k = 0; k < 3000 && busy; k++)
      @(posedge clock);
    if (busy)
    begin
      failCount++;
      end_sim;
    end
    repeat (3) @(posedge clock);
  endtask
  // read answers are compared in the cycle after the strobe
  always @(posedge clock) rdPend <= regRead;
  always @(negedge clock)
  begin
    irqSeen <= irq;
    if (!rstn)
      trigCount <= 16'h0000;
    else if (adcTrigger)
      trigCount <= trigCount + 16'h0001;
    if (rdPend)
      check(regRdata, expQ.pop_front());
  end
  initial
  begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  initial
  begin
    {rstn, regWrite, regRead, idleMode, start, rdPend, failCount, totalChecks} = '0;
    {regAddr, regWdata, pulses, pinSel, gateLevel, gap} = '0;
    seed = 32'h2662243F;
    repeat (20) @(posedge clock);
    rstn <= 1'b1;
    @(posedge clock);
    for (i = 0; i < 16; i++)
      rd(i[3:0], (i == 4 || i == 5) ? 16'hFFFF : 16'h0000);
    for (i = 0; i < 8; i++)
    begin
      r = $random(seed) & 32'h7FFF;
      wr({3'h0, i[0]}, r[15:0]);
      rd({3'h0, i[0]}, r[15:0] & (i[0] ? 16'hA072 : 16'hA07A));
      wr({1'b1, i[2:0]}, r[15:0]);
      rd({1'b1, i[2:0]}, 16'h0000);
    end
    wr(4'h1, 16'h0000);
    for (i = 0; i < 4; i++)
    begin
      wr(4'h2, 16'h0000);
      wr(4'h0, 16'h8002 | {10'h000, i[1:0], 4'h0});
      pulse(9'd256, 2'b01, 2'd1);
      rd(4'h2, psExp[i]);
      wr(4'h0, 16'h0002);
    end
    idleMode <= 1'b1;
    wr(4'h2, 16'h0000);
    wr(4'h0, 16'hA042);
    pulse(9'd4, 2'b01, 2'd3);
    rd(4'h2, 16'h0000);
    wr(4'h0, 16'h8042);
    pulse(9'd4, 2'b01, 2'd3);
    rd(4'h2, 16'h0004);
    idleMode <= 1'b0;
    wr(4'h0, 16'h0002);
    pulse(9'd3, 2'b01, 2'd1);
    rd(4'h2, 16'h0004);
    wr(4'h0, 16'h8040);
    repeat (40) idle;
    rd(4'h2, 16'h0004);
    gateLevel <= 2'b01;
    wr(4'h0, 16'h8050);
    repeat (20) idle;
    rd(4'h2, 16'h0005);
    gateLevel <= 2'b00;
    wr(4'h0, 16'h0002);
    wr(4'h1, 16'h8002);
    pulse(9'd5, 2'b11, 2'd1);
    rd(4'h3, 16'h0005);
    rd(4'h2, 16'h0005);
    wr(4'h7, 16'h0002);
    wr(4'h1, 16'h8032);
    wr(4'h2, 16'hFFFE);
    wr(4'h3, 16'h0000);
    wr(4'h4, 16'h0002);
    wr(4'h5, 16'h0001);
    wr(4'h0, 16'h800A);
    pulse(9'd3, 2'b11, 2'd1);
    rd(4'h2, 16'h0001);
    rd(4'h3, 16'h0001);
    pulse(9'd2, 2'b01, 2'd1);
    rd(4'h2, 16'h0000);
    rd(4'h6, 16'h0002);
    check(trigCount, 16'h0001);
    check({15'h0000, irqSeen}, 16'h0001);
    wr(4'h6, 16'h0003);
    rd(4'h6, 16'h0000);
    check({15'h0000, irqSeen}, 16'h0000);
    idle;
    rstn <= 1'b0;
    repeat (2) @(posedge clock);
    rstn <= 1'b1;
    @(posedge clock);
    rd(4'h0, 16'h0000);
    rd(4'h7, 16'h0000);
    repeat (3) idle;
    end_sim;
  end
endmodule
